// File: src/cssw_clock_switch.sv
// clock source switch: pll input selectors, main clock selector, ahb divider
// assumes source clocks arrive as one-cycle enable ticks synchronous to clk
//
// Functional notes
// - system pll input: 0 irc, 1 sysosc
// - pll input applied on update 0 then 1
// - pll update bit resets 0, 1 applies
// - usb pll input: 0 irc, 1 sysosc
// - usb input applied on update 0 then 1
// - main: irc, pll input, watchdog, pll out
// - main applied on update 0 then 1
// - ahb tick divides main by n, 0 stops
// - all selectors reset to irc
`timescale 1ns/10ps
`default_nettype none
module cssw_clock_switch (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rdata,
   // source clock ticks
   input wire logic internal_rc_oscillator,
   input wire logic sysosc_tick,
   input wire logic watchdog_oscillator,
   input wire logic pll_out_tick,
   // switched clock ticks
   output logic syspll_in_tick,
   output logic usbpll_in_tick,
   output logic main_tick,
   output logic ahb_tick,
   output logic ahb_stopped
);

   ////////////////////////////////////////////////////////////////////////////
   // register storage

   logic [1:0] syspll_input_select_ff;
   logic syspll_input_update_ff;
   logic [1:0] usbpll_input_select_ff;
   logic usbpll_input_update_ff;
   logic [1:0] main_clock_select_ff;
   logic main_clock_update_ff;
   logic [7:0] ahb_clock_divider_ff;
   logic [7:0] div_cnt_ff;
   logic [7:0] nxt_div_cnt;
   logic ahb_tick_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;

   ////////////////////////////////////////////////////////////////////////////
   // write decode

   wire logic sp_sel_wr = wr_stb && (addr == cssw_pkg::SYSPLL_SEL_ADDR);
   wire logic sp_upd_wr = wr_stb && (addr == cssw_pkg::SYSPLL_UPD_ADDR);
   wire logic usb_sel_wr = wr_stb && (addr == cssw_pkg::USBPLL_SEL_ADDR);
   wire logic usb_upd_wr = wr_stb && (addr == cssw_pkg::USBPLL_UPD_ADDR);
   wire logic main_sel_wr = wr_stb && (addr == cssw_pkg::MAIN_SEL_ADDR);
   wire logic main_upd_wr = wr_stb && (addr == cssw_pkg::MAIN_UPD_ADDR);
   wire logic div_wr = wr_stb && (addr == cssw_pkg::AHB_DIV_ADDR);
   wire logic upd_bit = wdata[cssw_pkg::UPD_BIT];

   // pll inputs only know codes 0 and 1; reserved codes never trigger a switch
   function automatic logic pll_code_ok(input logic [1:0] code);
      pll_code_ok = (code == cssw_pkg::SRC_IRC) || (code == cssw_pkg::SRC_SYSOSC);
   endfunction : pll_code_ok

   // a switch is requested only by a 0 to 1 transition of the update bit
   function automatic logic rises(input logic wr, input logic bit_new, input logic bit_old);
      rises = wr && bit_new && !bit_old;
   endfunction : rises

   wire logic sp_apply = rises(sp_upd_wr, upd_bit, syspll_input_update_ff)
      && pll_code_ok(syspll_input_select_ff);
   wire logic usb_apply = rises(usb_upd_wr, upd_bit, usbpll_input_update_ff)
      && pll_code_ok(usbpll_input_select_ff);
   wire logic main_apply = rises(main_upd_wr, upd_bit, main_clock_update_ff);

   ////////////////////////////////////////////////////////////////////////////
   // software registers

   // selectors hold the wish; only an update edge moves the real source
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         syspll_input_select_ff <= cssw_pkg::SEL_RST;
         usbpll_input_select_ff <= cssw_pkg::SEL_RST;
         main_clock_select_ff <= cssw_pkg::SEL_RST;
         ahb_clock_divider_ff <= cssw_pkg::DIV_RST;
      end
      else
      begin
         if (sp_sel_wr)
            syspll_input_select_ff <= wdata[1:0];
         if (usb_sel_wr)
            usbpll_input_select_ff <= wdata[1:0];
         if (main_sel_wr)
            main_clock_select_ff <= wdata[1:0];
         if (div_wr)
            ahb_clock_divider_ff <= wdata[7:0];
      end
   end

   // update bits simply store what was written; their edge is the trigger
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         syspll_input_update_ff <= cssw_pkg::UPD_RST;
         usbpll_input_update_ff <= cssw_pkg::UPD_RST;
         main_clock_update_ff <= cssw_pkg::UPD_RST;
      end
      else
      begin
         if (sp_upd_wr)
            syspll_input_update_ff <= upd_bit;
         if (usb_upd_wr)
            usbpll_input_update_ff <= upd_bit;
         if (main_upd_wr)
            main_clock_update_ff <= upd_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // source selection

   logic [1:0] sp_active;
   logic [1:0] usb_active;
   logic [1:0] main_active;
   logic sp_busy;
   logic usb_busy;
   logic main_busy;

   // system pll input: code 0 irc, code 1 system oscillator
   cssw_glitch_mux #(.N(4), .SW(2)) u_syspll_mux (
      .clk(clk),
      .sys_rst(sys_rst),
      .src_tick({2'b00, sysosc_tick, internal_rc_oscillator}),
      .sel_in(syspll_input_select_ff),
      .apply(sp_apply),
      .out_tick(syspll_in_tick),
      .active_sel(sp_active),
      .busy(sp_busy)
   );

   // usb pll input: same codes, own selector and update bit
   cssw_glitch_mux #(.N(4), .SW(2)) u_usbpll_mux (
      .clk(clk),
      .sys_rst(sys_rst),
      .src_tick({2'b00, sysosc_tick, internal_rc_oscillator}),
      .sel_in(usbpll_input_select_ff),
      .apply(usb_apply),
      .out_tick(usbpll_in_tick),
      .active_sel(usb_active),
      .busy(usb_busy)
   );

   // main clock: irc, system pll input, watchdog oscillator, system pll output
   cssw_glitch_mux #(.N(4), .SW(2)) u_main_mux (
      .clk(clk),
      .sys_rst(sys_rst),
      .src_tick({pll_out_tick, watchdog_oscillator, syspll_in_tick,
         internal_rc_oscillator}),
      .sel_in(main_clock_select_ff),
      .apply(main_apply),
      .out_tick(main_tick),
      .active_sel(main_active),
      .busy(main_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // ahb clock divider

   // count main ticks; a divider change is compared against the running count at once, so the current cut can end early or late
   wire logic div_off = (ahb_clock_divider_ff == 8'h00);
   wire logic div_wrap = (div_cnt_ff >= ahb_clock_divider_ff - 8'h01);

   always_comb
   begin
      nxt_div_cnt = div_cnt_ff;
      if (div_off)
         nxt_div_cnt = 8'h00;
      else if (main_tick)
         nxt_div_cnt = div_wrap ? 8'h00 : div_cnt_ff + 8'h01;
   end

   // ahb tick is registered, one cycle behind the main tick that ends a count
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         div_cnt_ff <= 8'h00;
         ahb_tick_ff <= 1'b0;
      end
      else
      begin
         div_cnt_ff <= nxt_div_cnt;
         ahb_tick_ff <= main_tick && !div_off && div_wrap;
      end
   end

   assign ahb_tick = ahb_tick_ff;
   assign ahb_stopped = div_off;

   ////////////////////////////////////////////////////////////////////////////
   // read path

   wire logic [31:0] status_word = {23'h000000,
      main_busy, usb_busy, sp_busy, main_active, usb_active, sp_active};

   // unmapped addresses and reserved bits read as zero
   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      case (addr)
         cssw_pkg::SYSPLL_SEL_ADDR: nxt_rdata = {30'h0, syspll_input_select_ff};
         cssw_pkg::SYSPLL_UPD_ADDR: nxt_rdata = {31'h0, syspll_input_update_ff};
         cssw_pkg::USBPLL_SEL_ADDR: nxt_rdata = {30'h0, usbpll_input_select_ff};
         cssw_pkg::USBPLL_UPD_ADDR: nxt_rdata = {31'h0, usbpll_input_update_ff};
         cssw_pkg::MAIN_SEL_ADDR: nxt_rdata = {30'h0, main_clock_select_ff};
         cssw_pkg::MAIN_UPD_ADDR: nxt_rdata = {31'h0, main_clock_update_ff};
         cssw_pkg::AHB_DIV_ADDR: nxt_rdata = {24'h0, ahb_clock_divider_ff};
         cssw_pkg::STATUS_ADDR: nxt_rdata = status_word;
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         rdata_ff <= 32'h0000_0000;
      else
         rdata_ff <= rd_stb ? nxt_rdata : 32'h0000_0000;
   end

   assign rdata = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking sw_cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence sp_arm_s;
      sp_upd_wr && !upd_bit;
   endsequence

   // the fire step only counts as an edge while the stored bit is still 0
   sequence sp_fire_s;
      sp_upd_wr && upd_bit && !syspll_input_update_ff && pll_code_ok(syspll_input_select_ff)
         && syspll_input_select_ff != sp_active && !sp_busy;
   endsequence

   sequence usb_arm_s;
      usb_upd_wr && !upd_bit;
   endsequence

   sequence usb_fire_s;
      usb_upd_wr && upd_bit && !usbpll_input_update_ff && pll_code_ok(usbpll_input_select_ff)
         && usbpll_input_select_ff != usb_active && !usb_busy;
   endsequence

   sequence main_arm_s;
      main_upd_wr && !upd_bit;
   endsequence

   sequence main_fire_s;
      main_upd_wr && upd_bit && !main_clock_update_ff
         && main_clock_select_ff != main_active && !main_busy;
   endsequence

   // the 0 and the 1 may be a few cycles apart, software rarely writes back to back
   sp_two_step_a: assert property (sp_arm_s ##[1:4] sp_fire_s |=> sp_busy)
      else $error("pll input update edge did not start a switch");
   sp_zero_only_a: assert property ((sp_arm_s and !sp_busy) |=> !sp_busy)
      else $error("writing zero moved the pll input");
   sp_upd_store_a: assert property (sp_upd_wr |=> syspll_input_update_ff == $past(upd_bit))
      else $error("pll update bit not stored");
   sp_osc_map_a: assert property ((!sp_busy && sp_active == cssw_pkg::SRC_SYSOSC)
      |-> syspll_in_tick == sysosc_tick)
      else $error("pll input code 1 not the system oscillator");
   usb_irc_map_a: assert property ((!usb_busy && usb_active == cssw_pkg::SRC_IRC)
      |-> usbpll_in_tick == internal_rc_oscillator)
      else $error("usb input code 0 not the irc");
   usb_two_step_a: assert property (usb_arm_s ##[1:4] usb_fire_s |=> usb_busy ##1 usb_busy)
      else $error("usb input update edge did not start a switch");
   main_wdt_map_a: assert property ((!main_busy && main_active == cssw_pkg::MAIN_WDT)
      |-> main_tick == watchdog_oscillator)
      else $error("main code 2 not the watchdog oscillator");
   main_no_repeat_a: assert property ((main_upd_wr && upd_bit && main_clock_update_ff
      && !main_busy) |=> !main_busy)
      else $error("second write of one retriggered main switch");
   div_stop_a: assert property (div_off [*2] |-> !ahb_tick)
      else $error("ahb tick while divider is zero");
   div_one_a: assert property ((main_tick && ahb_clock_divider_ff == 8'h01) |=> ahb_tick)
      else $error("divide by one dropped a tick");
   reset_irc_a: assert property (@(posedge clk) disable iff (1'b0)
      sys_rst |=> (sp_active == 2'h0 && usb_active == 2'h0 && main_active == 2'h0))
      else $error("selectors not on irc after reset");

   // main selector follows the same two-step update as the pll inputs
   main_two_step_a: assert property (main_arm_s ##[1:4] main_fire_s |=> main_busy)
      else $error("main update edge did not start a switch");
   usb_zero_only_a: assert property ((usb_arm_s and !usb_busy) |=> !usb_busy)
      else $error("writing zero moved the usb input");
   main_zero_only_a: assert property ((main_arm_s and !main_busy) |=> !main_busy)
      else $error("writing zero moved the main clock");
   usb_upd_store_a: assert property (usb_upd_wr |=> usbpll_input_update_ff == $past(upd_bit))
      else $error("usb update bit not stored");
   main_upd_store_a: assert property (main_upd_wr |=> main_clock_update_ff == $past(upd_bit))
      else $error("main update bit not stored");

   // reserved pll codes must never start a changeover
   sp_reserved_a: assert property ((sp_upd_wr && upd_bit && !pll_code_ok(syspll_input_select_ff)
      && !sp_busy) |=> !sp_busy)
      else $error("reserved pll input code started a switch");
   usb_reserved_a: assert property ((usb_upd_wr && upd_bit && !pll_code_ok(usbpll_input_select_ff)
      && !usb_busy) |=> !usb_busy)
      else $error("reserved usb input code started a switch");

   // once idle, each code passes exactly its own source tick
   sp_irc_map_a: assert property ((!sp_busy && sp_active == cssw_pkg::SRC_IRC)
      |-> syspll_in_tick == internal_rc_oscillator)
      else $error("pll input code 0 not the irc");
   usb_osc_map_a: assert property ((!usb_busy && usb_active == cssw_pkg::SRC_SYSOSC)
      |-> usbpll_in_tick == sysosc_tick)
      else $error("usb input code 1 not the system oscillator");
   main_irc_map_a: assert property ((!main_busy && main_active == cssw_pkg::MAIN_IRC)
      |-> main_tick == internal_rc_oscillator)
      else $error("main code 0 not the irc");
   main_pll_in_map_a: assert property ((!main_busy && main_active == cssw_pkg::MAIN_PLL_IN)
      |-> main_tick == syspll_in_tick)
      else $error("main code 1 not the pll input clock");
   main_pll_out_map_a: assert property ((!main_busy && main_active == cssw_pkg::MAIN_PLL_OUT)
      |-> main_tick == pll_out_tick)
      else $error("main code 3 not the pll output");

   // an ahb tick only ever follows a main tick, the divider never invents edges
   div_follow_a: assert property (ahb_tick |-> $past(main_tick))
      else $error("ahb tick without a main tick before it");
   rd_idle_a: assert property (!rd_stb |=> rdata == 32'h0000_0000)
      else $error("read data present without a read strobe");

endmodule : cssw_clock_switch
`default_nettype wire

// File: src/cssw_pkg.sv
// clock source switch: register map, field layout, reset values and source codes
// assumes a 32-bit register port addressed by full byte address
package cssw_pkg;

   // register byte addresses
   localparam logic [31:0] SYSPLL_SEL_ADDR = 32'h4004_8040;
   localparam logic [31:0] SYSPLL_UPD_ADDR = 32'h4004_8044;
   localparam logic [31:0] USBPLL_SEL_ADDR = 32'h4004_8048;
   localparam logic [31:0] USBPLL_UPD_ADDR = 32'h4004_804C;
   localparam logic [31:0] MAIN_SEL_ADDR = 32'h4004_8070;
   localparam logic [31:0] MAIN_UPD_ADDR = 32'h4004_8074;
   localparam logic [31:0] AHB_DIV_ADDR = 32'h4004_8078;
   localparam logic [31:0] STATUS_ADDR = 32'h4004_80F0;

   // field layout
   localparam int SEL_W = 2;
   localparam int DIV_W = 8;
   localparam int UPD_BIT = 0;
   localparam int STAT_SYSPLL_LSB = 0;
   localparam int STAT_USBPLL_LSB = 2;
   localparam int STAT_MAIN_LSB = 4;
   localparam int STAT_BUSY_LSB = 6;

   // reset values
   localparam logic [1:0] SEL_RST = 2'h0;
   localparam logic UPD_RST = 1'b0;
   localparam logic [7:0] DIV_RST = 8'h01;

   // source codes
   localparam logic [1:0] SRC_IRC = 2'h0;
   localparam logic [1:0] SRC_SYSOSC = 2'h1;
   localparam logic [1:0] MAIN_IRC = 2'h0;
   localparam logic [1:0] MAIN_PLL_IN = 2'h1;
   localparam logic [1:0] MAIN_WDT = 2'h2;
   localparam logic [1:0] MAIN_PLL_OUT = 2'h3;

endpackage : cssw_pkg

// File: src/cssw_glitch_mux.sv
// glitch-free selector between several tick streams (one-cycle clock enables)
// assumes every selected source keeps ticking while a changeover is pending
`timescale 1ns/10ps
`default_nettype none
module cssw_glitch_mux #(
   parameter int N = 4,
   parameter int SW = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // sources and control
   input wire logic [N-1:0] src_tick,
   input wire logic [SW-1:0] sel_in,
   input wire logic apply,
   // switched output and state
   output logic out_tick,
   output logic [SW-1:0] active_sel,
   output logic busy
);

   typedef enum logic [1:0] {CSSW_RUN, CSSW_WAIT_OLD, CSSW_WAIT_NEW} cssw_mux_state_e;

   cssw_mux_state_e state_ff;
   cssw_mux_state_e nxt_state;
   logic [SW-1:0] cur_ff;
   logic [SW-1:0] tgt_ff;
   logic [SW-1:0] nxt_cur;
   wire logic cur_tick = src_tick[cur_ff];
   wire logic start = apply && (state_ff == CSSW_RUN) && (sel_in != cur_ff);

   // the first tick of the new source is swallowed so no period comes out short
   assign out_tick = (state_ff != CSSW_WAIT_NEW) && cur_tick;
   assign active_sel = cur_ff;
   assign busy = (state_ff != CSSW_RUN);

   // changeover sequencing: finish old period, then realign on the new source
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cur = cur_ff;
      case (state_ff)
         CSSW_RUN:
         begin
            if (start)
               nxt_state = CSSW_WAIT_OLD;
         end
         CSSW_WAIT_OLD:
         begin
            if (cur_tick)
            begin
               nxt_state = CSSW_WAIT_NEW;
               nxt_cur = tgt_ff;
            end
         end
         CSSW_WAIT_NEW:
         begin
            if (cur_tick)
               nxt_state = CSSW_RUN;
         end
         default:
            nxt_state = CSSW_RUN;
      endcase
   end

   // state registers; selection returns to source zero on reset
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_ff <= CSSW_RUN;
         cur_ff <= '0;
         tgt_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         cur_ff <= nxt_cur;
         if (start)
            tgt_ff <= sel_in;
      end
   end

   default clocking mux_cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   new_gap_a: assert property ((state_ff == CSSW_WAIT_NEW) |-> !out_tick)
      else $error("tick leaked while aligning on new source");
   old_pass_a: assert property ((state_ff == CSSW_WAIT_OLD && cur_tick)
      |-> out_tick ##1 (state_ff == CSSW_WAIT_NEW && cur_ff == $past(tgt_ff)))
      else $error("old source period not closed before handover");

endmodule : cssw_glitch_mux
`default_nettype wire

// File: tb/cssw_clock_switch_tb_top.sv
// self-checking bench for the clock source switch: register port, selectors, ahb divider
// assumes the design's status register reports active codes and busy flags per selector
`timescale 1ns/10ps
`default_nettype none
module cssw_clock_switch_tb_top;
   logic clk, sys_rst, wr_stb, rd_stb;
   logic [31:0] addr, wdata, rdata, rv, lfsr_ff;
   logic rc_t, osc_t, wd_t, po_t;
   logic syspll_in_tick, usbpll_in_tick, main_tick, ahb_tick, ahb_stopped;
   logic [1:0] pll_a, usb_a, main_a, code;
   int miscompares, n_checks, cyc;
   logic [31:0] ra [8];
   logic [31:0] sel_a [3];
   logic [31:0] upd_a [3];

   ////////////////////////////////////////////////////////////////////////////
   cssw_clock_switch uut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .internal_rc_oscillator(rc_t),
      .sysosc_tick(osc_t), .watchdog_oscillator(wd_t), .pll_out_tick(po_t),
      .syspll_in_tick(syspll_in_tick), .usbpll_in_tick(usbpll_in_tick),
      .main_tick(main_tick), .ahb_tick(ahb_tick), .ahb_stopped(ahb_stopped));

   // clock generator
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // sources keep ticking at distinct rates so a wrong selection always shows
   // every source runs all the time, so both clocks run at each update
   // the irc is never stopped, so it cannot stop before the usb switch
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      rc_t <= (cyc % 3 == 0);
      osc_t <= (cyc % 4 == 1);
      wd_t <= (cyc % 5 == 2);
      po_t <= (cyc % 2 == 0);
      if (cyc == 30000)
      begin
         miscompares++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   // tick expected from a pll input code; reserved codes are never active
   function automatic logic exp_pll(input logic [1:0] c);
      return (c == cssw_pkg::SRC_SYSOSC) ? osc_t : rc_t;
   endfunction : exp_pll

   function automatic logic exp_main(input logic [1:0] c);
      case (c)
         2'h0: return rc_t;
         2'h1: return exp_pll(pll_a);
         2'h2: return wd_t;
         default: return po_t;
      endcase
   endfunction : exp_main

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////////
   // register port: one-cycle strobes, read data only in the following cycle
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask : wr

   task automatic rd(input logic [31:0] a);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      rv = rdata;
   endtask : rd

   // all three switched outputs must track the sources the bench expects
   task automatic follow();
      repeat (12)
      begin
         @(negedge clk);
         check({31'h0, syspll_in_tick}, {31'h0, exp_pll(pll_a)});
         check({31'h0, usbpll_in_tick}, {31'h0, exp_pll(usb_a)});
         check({31'h0, main_tick}, {31'h0, exp_main(main_a)});
      end
   endtask : follow

   // select, write 0 then 1 to update, poll busy with a bound, check active code
   task automatic sw(input int idx, input logic [1:0] c, input logic [1:0] exp);
      int k;
      wr(sel_a[idx], {30'h0, c});
      wr(upd_a[idx], 32'h0);
      wr(upd_a[idx], 32'h1);
      for (k = 0; k < 50; k++)
      begin
         rd(cssw_pkg::STATUS_ADDR);
         if (rv[cssw_pkg::STAT_BUSY_LSB + idx] === 1'b0)
            break;
      end
      check({30'h0, rv[2 * idx +: 2]}, {30'h0, exp});
      follow();
   endtask : sw

   task automatic reset_chk();
      for (int i = 0; i < 8; i++)
      begin
         rd(ra[i]);
         check(rv, (i == 6) ? {24'h0, cssw_pkg::DIV_RST} : 32'h0);
      end
      follow();
   endtask : reset_chk

   // count ahb ticks over a window of 2n main ticks (20 when n is 0) once the divider settled
   task automatic div_run(input logic [7:0] n);
      int m, a, s, k;
      logic pm;
      wr(cssw_pkg::AHB_DIV_ADDR, {24'h0, n});
      rd(cssw_pkg::AHB_DIV_ADDR);
      check(rv, {24'h0, n});
      m = 0;
      a = 0;
      pm = 1'b0;
      s = int'(n) + 1;
      k = (n == 8'h00) ? 20 : 2 * int'(n);
      while (!(m == s + k && !pm))
      begin
         @(negedge clk);
         if (pm && m > s)
            a += int'(ahb_tick);
         pm = main_tick;
         if (main_tick)
            m++;
      end
      check(a, (n == 8'h00) ? 0 : 2);
      check({31'h0, ahb_stopped}, {31'h0, n == 8'h00});
   endtask : div_run

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      ra = '{cssw_pkg::SYSPLL_SEL_ADDR, cssw_pkg::SYSPLL_UPD_ADDR, cssw_pkg::USBPLL_SEL_ADDR,
         cssw_pkg::USBPLL_UPD_ADDR, cssw_pkg::MAIN_SEL_ADDR, cssw_pkg::MAIN_UPD_ADDR,
         cssw_pkg::AHB_DIV_ADDR, cssw_pkg::STATUS_ADDR};
      sel_a = '{cssw_pkg::SYSPLL_SEL_ADDR, cssw_pkg::USBPLL_SEL_ADDR, cssw_pkg::MAIN_SEL_ADDR};
      upd_a = '{cssw_pkg::SYSPLL_UPD_ADDR, cssw_pkg::USBPLL_UPD_ADDR, cssw_pkg::MAIN_UPD_ADDR};
      sys_rst = 1'b1;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      addr = 32'h0;
      wdata = 32'h0;
      {rc_t, osc_t, wd_t, po_t} = 4'h0;
      cyc = 0;
      miscompares = 0;
      n_checks = 0;
      lfsr_ff = 32'h43468983;
      {pll_a, usb_a, main_a} = 6'h00;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      reset_chk();
      // unmapped place reads zero and ignores writes
      wr(32'h4004_8050, 32'hFFFF_FFFF);
      rd(32'h4004_8050);
      check(rv, 32'h0);
      // a lone zero write to update must not switch
      wr(cssw_pkg::SYSPLL_SEL_ADDR, 32'h1);
      wr(cssw_pkg::SYSPLL_UPD_ADDR, 32'h0);
      rd(cssw_pkg::STATUS_ADDR);
      check({30'h0, rv[1:0]}, 32'h0);
      // system oscillator feeds the system pll, as usb clocking wants
      pll_a = 2'h1;
      sw(0, 2'h1, pll_a);
      // writing 1 again without the 0 first changes nothing
      wr(cssw_pkg::SYSPLL_SEL_ADDR, 32'h0);
      wr(cssw_pkg::SYSPLL_UPD_ADDR, 32'h1);
      rd(cssw_pkg::SYSPLL_UPD_ADDR);
      check(rv, 32'h1);
      rd(cssw_pkg::STATUS_ADDR);
      check({30'h0, rv[1:0]}, 32'h1);
      follow();
      // usb input moved to the oscillator, then a reserved code is ignored
      usb_a = 2'h1;
      sw(1, 2'h1, usb_a);
      sw(1, 2'h3, usb_a);
      // random codes on both pll inputs
      for (int i = 0; i < 12; i++)
      begin
         lfsr_ff = lfsr(lfsr_ff);
         code = lfsr_ff[1:0];
         if (i % 2 == 0 && code < 2'h2)
            pll_a = code;
         if (i % 2 == 1 && code < 2'h2)
            usb_a = code;
         sw(i % 2, code, (i % 2 == 0) ? pll_a : usb_a);
      end
      // every main code in turn, then random ones, ending on the pll output
      for (int i = 0; i < 9; i++)
      begin
         lfsr_ff = lfsr(lfsr_ff);
         main_a = (i < 4) ? 2'(i) : ((i == 8) ? 2'h3 : lfsr_ff[1:0]);
         sw(2, main_a, main_a);
      end
      // divider corners and random values
      div_run(8'h01);
      div_run(8'h02);
      div_run(8'hFF);
      div_run(8'h00);
      for (int i = 0; i < 3; i++)
      begin
         lfsr_ff = lfsr(lfsr_ff);
         div_run(lfsr_ff[7:0]);
      end
      // reset in mid-run returns every selector and the divider to defaults
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      {pll_a, usb_a, main_a} = 6'h00;
      reset_chk();
      end_of_test();
   end
endmodule : cssw_clock_switch_tb_top
`default_nettype wire
